// ==== rtl/ccs_channel.sv ====
// Contract
// - Ack or software zero clears pending flag
// - Clock source zero drives internal clock out
// - Handshake enabled at zero; select zero picks CTS
// - Polarity zero: drive falling, sample rising
// - Source zero: request when buffer empties
// - Source bits at shared 0,1 and channel2 4
// - Empty flag sets on move to shifter
// - Receive buffer read drives RTS low
`default_nettype none

module ccs_channel
    import ccs_pkg::*;
(
    // System clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Transfer clock and serial pins
    input wire logic link_clk_i,
    input wire logic rxd_i,
    input wire logic cts_n_i,
    output logic txd_o,
    output logic transfer_clock_pin_o,
    output logic transfer_clock_pin_oe_o,
    output logic request_to_send_out_n_o,
    // Interrupt controller
    input wire logic irq_ack_i,
    output logic irq_request_o
);
    // ****************************************************************
    // Bus decode
    // ****************************************************************
    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] reg_adr);
        return adr == reg_adr;
    endfunction : hit

    logic ack_q;
    logic [31:0] dat_q;
    logic req;
    logic acc;
    logic wr;
    logic rd;
    assign req = wb_cyc_i & wb_stb_i;
    assign acc = req & ack_q;
    assign wr = acc & wb_we_i & wb_sel_i[0];
    assign rd = acc & ~wb_we_i;

    logic [CTL_W-1:0] ctrl_q;
    logic [1:0] shared_q;
    logic ch2_src_q;
    logic [7:0] tx_buf_q;
    logic tx_empty_q;
    logic [7:0] tx_word_q;
    logic [7:0] rx_buf_q;
    logic rx_full_q;
    logic irq_q;
    logic rts_n_q;
    logic oe_q;
    logic clk_pin_q;
    logic [4:0] gen_cnt_q;
    logic [1:0] div_q;
    logic done_prev_q;
    ccs_tx_e st_q;

    // ****************************************************************
    // Clock domain crossings
    // ****************************************************************
    ccs_link_if lk ();
    logic cts_n_s;
    logic done_s;
    logic link_rst;

    ccs_sync2 u_cts (
        .clk_i(clk_i),
        .d_i(cts_n_i),
        .q_o(cts_n_s)
    );
    ccs_sync2 u_done (
        .clk_i(clk_i),
        .d_i(lk.done_tgl),
        .q_o(done_s)
    );
    ccs_sync2 u_lrst (
        .clk_i(link_clk_i),
        .d_i(rst_i),
        .q_o(link_rst)
    );
    ccs_link_shift u_shift (
        .link_clk_i(link_clk_i),
        .link_rst_i(link_rst),
        .rxd_i(rxd_i),
        .txd_o(txd_o),
        .lk(lk.link)
    );
    // The word is held stable for the whole frame, so the link side
    // may read it without its own synchroniser.
    assign lk.tx_word = tx_word_q;
    assign lk.polarity = ctrl_q[CTL_POL];

    // ****************************************************************
    // Transmit sequencing
    // ****************************************************************
    logic internal_clk;
    logic cts_ok;
    logic load;
    logic done_evt;
    logic src_sel;
    logic irq_set;
    logic irq_clr;
    assign internal_clk = ~ctrl_q[CTL_CLKSRC];
    assign cts_ok = ctrl_q[CTL_HSDIS] | ctrl_q[CTL_HSSEL] |
                    ~cts_n_s;
    // Reception with the internal clock only runs once software has
    // enabled transmit and written a dummy word.
    assign load = (st_q == CCS_TX_IDLE) & ~tx_empty_q &
                  ctrl_q[CTL_TXEN] & cts_ok;
    assign done_evt = done_s ^ done_prev_q;
    assign src_sel = shared_q[CHANNEL];
    assign irq_set = src_sel ? (done_evt & (st_q == CCS_TX_RUN))
                             : load;
    assign irq_clr = irq_ack_i |
                     (wr & hit(wb_adr_i, ADR_IRQ) & ~wb_dat_i[IRQ_PEND]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= CCS_TX_IDLE;
            tx_word_q <= TXBUF_RST;
            done_prev_q <= 1'b0;
        end else begin
            done_prev_q <= done_s;
            case (st_q)
                CCS_TX_IDLE: begin
                    if (load) begin
                        tx_word_q <= tx_buf_q;
                        st_q <= CCS_TX_RUN;
                    end
                end
                CCS_TX_RUN: begin
                    if (done_evt) begin
                        st_q <= CCS_TX_IDLE;
                    end
                end
                default: st_q <= CCS_TX_IDLE;
            endcase
        end
    end

    // Transmit buffer; a write in the load cycle keeps the new word.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_buf_q <= TXBUF_RST;
            tx_empty_q <= 1'b1;
        end else begin
            if (load) begin
                tx_empty_q <= 1'b1;
            end
            if (wr && hit(wb_adr_i, ADR_TXBUF)) begin
                tx_buf_q <= wb_dat_i[7:0];
                tx_empty_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Internal transfer clock
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_cnt_q <= 5'h0;
            div_q <= 2'h0;
            clk_pin_q <= 1'b1;
        end else if (load && internal_clk) begin
            gen_cnt_q <= 5'(EDGES);
            div_q <= 2'h0;
        end else if (gen_cnt_q != 5'h0) begin
            if (div_q == 2'(HALF_CYC - 1)) begin
                div_q <= 2'h0;
                clk_pin_q <= ~clk_pin_q;
                gen_cnt_q <= gen_cnt_q - 5'h1;
            end else begin
                div_q <= div_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= internal_clk;
        end
    end

    // ****************************************************************
    // Receive buffer and handshake output
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_buf_q <= 8'h00;
            rx_full_q <= 1'b0;
            rts_n_q <= 1'b0;
        end else begin
            if (rd && hit(wb_adr_i, ADR_RXBUF)) begin
                rx_full_q <= 1'b0;
                rts_n_q <= 1'b0;
            end
            if (done_evt && ctrl_q[CTL_RXEN]) begin
                rx_buf_q <= lk.rx_word;
                rx_full_q <= 1'b1;
                rts_n_q <= 1'b1;
            end
            if (ctrl_q[CTL_HSDIS] || !ctrl_q[CTL_HSSEL]) begin
                rts_n_q <= 1'b0;
            end
        end
    end

    // Hardware set wins over any clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_set | (irq_q & ~irq_clr);
        end
    end

    // ****************************************************************
    // Register file and bus answer
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            shared_q <= SHARED_RST;
            ch2_src_q <= C2_RST;
        end else if (wr) begin
            if (hit(wb_adr_i, ADR_CTRL)) begin
                ctrl_q <= wb_dat_i[CTL_W-1:0];
            end
            if (hit(wb_adr_i, ADR_SHARED)) begin
                shared_q <= wb_dat_i[SH_SRC1:SH_SRC0];
            end
            if (hit(wb_adr_i, ADR_CH2)) begin
                ch2_src_q <= wb_dat_i[C2_SRC];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= req & ~ack_q;
            dat_q <= 32'h0;
            case (wb_adr_i)
                ADR_CTRL: dat_q[CTL_W-1:0] <= ctrl_q;
                ADR_SHARED: dat_q[SH_SRC1:SH_SRC0] <= shared_q;
                ADR_CH2: dat_q[C2_SRC] <= ch2_src_q;
                ADR_STATUS: begin
                    dat_q[ST_TXEMPTY] <= tx_empty_q;
                    dat_q[ST_RXFULL] <= rx_full_q;
                    dat_q[ST_BUSY] <= st_q == CCS_TX_RUN;
                    dat_q[ST_RTS] <= rts_n_q;
                end
                ADR_TXBUF: dat_q[7:0] <= tx_buf_q;
                ADR_RXBUF: dat_q[7:0] <= rx_buf_q;
                ADR_IRQ: dat_q[IRQ_PEND] <= irq_q;
                default: dat_q <= 32'h0;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign irq_request_o = irq_q;
    assign request_to_send_out_n_o = rts_n_q;
    assign transfer_clock_pin_o = clk_pin_q;
    assign transfer_clock_pin_oe_o = oe_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_ack_clears_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_q && irq_ack_i && !irq_set |=> !irq_request_o)
        else $error("acknowledge did not clear pending flag");
    a_sw_clears_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && hit(wb_adr_i, ADR_IRQ) && !wb_dat_i[IRQ_PEND] && !irq_set
        |=> !irq_request_o)
        else $error("software zero did not clear pending flag");
    a_clk_oe_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && hit(wb_adr_i, ADR_CTRL) && !wb_dat_i[CTL_CLKSRC]
        |=> ##1 transfer_clock_pin_oe_o)
        else $error("internal clock not driven on pin");
    a_clk_edges: assert property (@(posedge clk_i) disable iff (rst_i)
        load && internal_clk |=> gen_cnt_q == 5'(EDGES)
        ##1 $stable(transfer_clock_pin_o))
        else $error("transfer clock burst wrong");
    a_cts_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
        load && !ctrl_q[CTL_HSDIS] && !ctrl_q[CTL_HSSEL]
        |-> !$past(cts_n_i, 2))
        else $error("transfer started with clear-to-send high");
    a_empty_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        load && !src_sel |=> irq_request_o)
        else $error("no request when buffer emptied");
    a_load_empty: assert property (@(posedge clk_i) disable iff (rst_i)
        load && !(wr && hit(wb_adr_i, ADR_TXBUF))
        |=> tx_empty_q && st_q == CCS_TX_RUN)
        else $error("empty flag not set on move to shifter");
    a_rts_on_read: assert property (@(posedge clk_i) disable iff (rst_i)
        rd && hit(wb_adr_i, ADR_RXBUF) && !done_evt
        |=> !request_to_send_out_n_o)
        else $error("request-to-send not low after buffer read");
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge longer than one cycle");
endmodule : ccs_channel

`default_nettype wire

// ==== rtl/ccs_pkg.sv ====
`default_nettype none

package ccs_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_SHARED = 8'h04;
    localparam logic [7:0] ADR_CH2 = 8'h08;
    localparam logic [7:0] ADR_STATUS = 8'h0c;
    localparam logic [7:0] ADR_TXBUF = 8'h10;
    localparam logic [7:0] ADR_RXBUF = 8'h14;
    localparam logic [7:0] ADR_IRQ = 8'h18;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTL_CLKSRC = 0;
    localparam int CTL_POL = 1;
    localparam int CTL_HSDIS = 2;
    localparam int CTL_HSSEL = 3;
    localparam int CTL_TXEN = 4;
    localparam int CTL_RXEN = 5;
    localparam int CTL_W = 6;
    localparam int SH_SRC0 = 0;
    localparam int SH_SRC1 = 1;
    localparam int C2_SRC = 4;
    localparam int ST_TXEMPTY = 0;
    localparam int ST_RXFULL = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_RTS = 3;
    localparam int IRQ_PEND = 0;
    localparam int CHANNEL = 0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [CTL_W-1:0] CTRL_RST = 6'h00;
    localparam logic [1:0] SHARED_RST = 2'h0;
    localparam logic C2_RST = 1'b0;
    localparam logic [7:0] TXBUF_RST = 8'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int WORD_BITS = 8;
    localparam int CLK_NS = 20;
    localparam int HALF_NS = 40;
    localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int EDGES = 2 * WORD_BITS;

    typedef enum logic {
        CCS_TX_IDLE,
        CCS_TX_RUN
    } ccs_tx_e;

endpackage : ccs_pkg

`default_nettype wire

// ==== rtl/ccs_link_if.sv ====
`default_nettype none

interface ccs_link_if;
    logic [7:0] tx_word;
    logic polarity;
    logic done_tgl;
    logic [7:0] rx_word;
    modport main (output tx_word, output polarity, input done_tgl,
                  input rx_word);
    modport link (input tx_word, input polarity, output done_tgl,
                  output rx_word);
endinterface : ccs_link_if

`default_nettype wire

// ==== rtl/ccs_sync2.sv ====
`default_nettype none

module ccs_sync2 (
    // Clock
    input wire logic clk_i,
    // Level from another domain
    input wire logic d_i,
    output logic q_o
);
    logic meta_q = 1'b0;

    always_ff @(posedge clk_i) begin
        meta_q <= d_i;
        q_o <= meta_q;
    end
endmodule : ccs_sync2

`default_nettype wire

// ==== rtl/ccs_link_shift.sv ====
`default_nettype none

module ccs_link_shift
    import ccs_pkg::*;
(
    // Transfer clock and reset synchronised to it
    input wire logic link_clk_i,
    input wire logic link_rst_i,
    // Serial data
    input wire logic rxd_i,
    output logic txd_o,
    // Word exchange with the register side
    ccs_link_if.link lk
);
    // ****************************************************************
    // Edge selection
    // ****************************************************************
    // Polarity is quasi-static; it must only change while idle, since
    // the inversion glitches the shift clock.
    logic sclk;
    assign sclk = link_clk_i ^ lk.polarity;

    // Power-up values cover a clock that stays still until the frame.
    logic [2:0] drv_cnt_q = 3'h0;
    logic [2:0] smp_cnt_q = 3'h0;
    logic [7:0] rx_sh_q = 8'h00;
    logic [7:0] rx_word_q = 8'h00;
    logic done_q = 1'b0;
    logic txd_q = 1'b1;

    // Drive edge: falling when polarity is zero.
    always_ff @(negedge sclk) begin
        if (link_rst_i) begin
            drv_cnt_q <= 3'h0;
            txd_q <= 1'b1;
        end else begin
            txd_q <= lk.tx_word[drv_cnt_q];
            drv_cnt_q <= drv_cnt_q + 3'h1;
        end
    end

    // Sample edge: rising when polarity is zero.
    always_ff @(posedge sclk) begin
        if (link_rst_i) begin
            smp_cnt_q <= 3'h0;
        end else begin
            rx_sh_q[smp_cnt_q] <= rxd_i;
            smp_cnt_q <= smp_cnt_q + 3'h1;
            if (smp_cnt_q == 3'(WORD_BITS - 1)) begin
                rx_word_q <= {rxd_i, rx_sh_q[6:0]};
                done_q <= ~done_q;
            end
        end
    end

    assign txd_o = txd_q;
    assign lk.rx_word = rx_word_q;
    assign lk.done_tgl = done_q;
endmodule : ccs_link_shift

`default_nettype wire

// ==== testbench/ccs_peer.sv ====
`default_nettype none

module ccs_peer (
    // Transfer clock as seen at the pin
    input wire logic lclk_i,
    input wire logic pol_i,
    // Serial data
    input wire logic txd_i,
    output logic rxd_o,
    // Clock made by the peer when the device takes an external clock
    output logic peer_clk_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] send_q;
    logic [7:0] got_q;
    int idx;
    bit active;

    initial begin
        rxd_o = 1'b1;
        peer_clk_o = 1'b1;
        active = 1'b0;
        idx = 0;
        got_q = 8'h00;
        send_q = 8'h00;
    end

    task automatic arm(input logic [7:0] w);
        send_q = w;
        got_q = 8'h00;
        idx = 0;
        active = 1'b1;
    endtask : arm

    // The clock rests high between frames, so no stray edge reaches
    // the shifter while the word is being set up.
    task automatic pulses(input int n);
        repeat (n) begin
            #7.5 peer_clk_o = 1'b0;
            #7.5 peer_clk_o = 1'b1;
        end
    endtask : pulses

    // Drive on the first edge, sample on the next, LSB first.
    always @(lclk_i) begin
        if (active) begin
            if (lclk_i ^ pol_i) begin
                got_q[idx] = txd_i;
                idx = idx + 1;
                if (idx == 8) begin
                    active = 1'b0;
                    // A released line must not keep looking like data.
                    rxd_o <= ~rxd_o;
                end
            end else begin
                rxd_o <= send_q[idx];
            end
        end
    end
endmodule : ccs_peer

`default_nettype wire

// ==== testbench/ccs_channel_tb.sv ====
`default_nettype none

module ccs_channel_tb
    import ccs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, r;
    logic link_clk, rxd, cts_n, txd, pin, pin_oe, rts_n;
    logic irq_ack, irq_req, peer_clk;
    int n_mismatch, check_count;
    int seed;
    int exp_q[$];
    logic [7:0] adrs[3] = '{ADR_CTRL, ADR_SHARED, ADR_CH2};
    logic [31:0] masks[3] = '{32'h3f, 32'h3, 32'h10};

    // The clock line is wired-AND, so the peer can still clock the link
    // side out of reset while the device drives its idle-high clock.
    assign link_clk = pin_oe ? (pin & peer_clk) : peer_clk;

    ccs_channel ccs_channel_inst (
        .clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
        .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
        .link_clk_i(link_clk), .rxd_i(rxd), .cts_n_i(cts_n),
        .txd_o(txd), .transfer_clock_pin_o(pin),
        .transfer_clock_pin_oe_o(pin_oe),
        .request_to_send_out_n_o(rts_n),
        .irq_ack_i(irq_ack), .irq_request_o(irq_req)
    );

    ccs_peer ccs_peer_inst (
        .lclk_i(link_clk), .pol_i(1'b0), .txd_i(txd),
        .rxd_o(rxd), .peer_clk_o(peer_clk)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_pin(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t: pin %b, expected %b", $time, got, exp);
        end
    endtask : chk_pin

    // The request is held until ack is sampled high at a rising edge.
    task automatic wb_io(input logic [7:0] a, input logic we,
                         input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= s;
        wb_dat_w <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        r = wb_dat_r;
        if (n >= 20) begin
            n_mismatch++;
            $display("[FAIL] %0t: no bus answer", $time);
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb_io

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_io(a, 1'b1, 4'h1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        wb_io(a, 1'b0, 4'hf, 32'h0);
    endtask : rd

    task automatic wait_status(input int b);
        int n;
        n = 0;
        do begin
            rd(ADR_STATUS);
            n++;
        end while (r[b] !== 1'b1 && n < 100);
        chk_pin(r[b], 1'b1);
    endtask : wait_status

    task automatic xfer(input logic [31:0] ctl, input bit ext,
                        input bit block, input bit by_ack);
        logic [7:0] txw;
        logic [7:0] rxw;
        txw = 8'($random(seed));
        rxw = 8'($random(seed));
        exp_q.push_back(int'(txw));
        exp_q.push_back(int'(rxw));
        wr(ADR_CTRL, ctl);
        wr(ADR_IRQ, 32'h0);
        ccs_peer_inst.arm(rxw);
        if (block) cts_n <= 1'b1;
        wr(ADR_TXBUF, {24'h0, txw});
        if (block) begin
            repeat (40) @(posedge clk_i);
            rd(ADR_STATUS);
            chk_pin(r[ST_TXEMPTY], 1'b0);
            chk_pin(irq_req, 1'b0);
            cts_n <= 1'b0;
        end
        wait_status(ST_TXEMPTY);
        chk_pin(irq_req, 1'b1);
        chk_pin(pin_oe, ~ext);
        if (ext) ccs_peer_inst.pulses(WORD_BITS);
        wait_status(ST_RXFULL);
        chk_val({24'h0, ccs_peer_inst.got_q}, exp_q.pop_front());
        chk_pin(rts_n, ctl[CTL_HSSEL]);
        rd(ADR_RXBUF);
        chk_val(r, exp_q.pop_front());
        repeat (2) @(posedge clk_i);
        chk_pin(rts_n, 1'b0);
        if (by_ack) begin
            irq_ack <= 1'b1;
            @(posedge clk_i);
            irq_ack <= 1'b0;
        end else begin
            wr(ADR_IRQ, 32'h0);
        end
        repeat (2) @(posedge clk_i);
        chk_pin(irq_req, 1'b0);
    endtask : xfer

    // ****************************************************************
    // Stimulus
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        $display("[FAIL] %0t: run did not finish", $time);
        stop_test();
    end

    initial begin
        seed = 32'h953f;
        n_mismatch = 0;
        check_count = 0;
        rst_i = 1'b1;
        {wb_cyc, wb_stb, wb_we, irq_ack, cts_n} = 5'h0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat_w = 32'h0;
        // The link side takes reset only while its clock runs.
        ccs_peer_inst.pulses(4);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        // Two rising edges carry the release into the link domain.
        ccs_peer_inst.pulses(2);
        rd(ADR_CTRL);
        chk_val(r, {26'h0, CTRL_RST});
        rd(ADR_STATUS);
        chk_pin(r[ST_TXEMPTY], 1'b1);
        rd(ADR_IRQ);
        chk_val(r, 32'h0);
        rd(8'h1c);
        chk_val(r, 32'h0);
        chk_pin(pin, 1'b1);
        chk_pin(pin_oe, 1'b1);
        chk_pin(txd, 1'b1);
        for (int i = 0; i < 3; i++) begin
            // Polarity stays zero: flipping it edges the idle shift clock.
            wr(adrs[i], $random(seed) & ~(32'(i == 0) << CTL_POL));
            exp_q.push_back(int'(wb_dat_w & masks[i]));
            wb_io(adrs[i], 1'b1, 4'h0, ~wb_dat_w);
            rd(adrs[i]);
            chk_val(r & masks[i], exp_q.pop_front());
        end
        wr(ADR_SHARED, 32'h0);
        xfer(32'h30, 1'b0, 1'b0, 1'b0);
        xfer(32'h30, 1'b0, 1'b1, 1'b1);
        xfer(32'h38, 1'b0, 1'b0, 1'b0);
        xfer(32'h31, 1'b1, 1'b0, 1'b1);
        // Completion-sourced request: nothing at load, set at the end.
        wr(ADR_CTRL, 32'h30);
        wr(ADR_SHARED, 32'h1);
        ccs_peer_inst.arm(8'h5a);
        wr(ADR_TXBUF, 32'ha5);
        wait_status(ST_TXEMPTY);
        chk_pin(irq_req, 1'b0);
        wait_status(ST_RXFULL);
        chk_pin(irq_req, 1'b1);
        chk_val({24'h0, ccs_peer_inst.got_q}, 32'ha5);
        rd(ADR_RXBUF);
        chk_val(r, 32'h5a);
        stop_test();
    end
endmodule : ccs_channel_tb

`default_nettype wire
